// ==== src/cs3_datapath.sv ====
// sinc3 decimator, interpolator and DAC modulator with APB registers
//
// Local design decisions: the placing of the registers and the APB register port.
`include "cs3_params.svh"
`default_nettype none
module cs3_datapath
	import cs3_pkg::*;
#(
	parameter int MCLK_DIV = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic adcModBit,
	output logic modStrobe,
	output logic [15:0] adcWord,
	output logic adcValid,
	input wire logic dacValid,
	input wire logic [15:0] dacWord,
	output logic dacBit,
	output logic [5:0] inGainDb,
	output logic signed [4:0] outGainDb
);
	initial begin
		if (MCLK_DIV < 1 || MCLK_DIV > 256) begin
			$error("MCLK_DIV out of range");
		end
	end

	cs3_state_t r;
	cs3_state_t n;
	logic mclkTick;
	logic modTick;
	logic sampTick;
	logic [8:0] nMax;
	logic dataMode;
	logic mixedMode;
	logic bypass;
	logic accept;
	logic apbWr;
	logic hit;
	logic signed [25:0] xin;
	logic signed [25:0] c1;
	logic signed [25:0] c2;
	logic signed [25:0] c3;
	logic signed [41:0] u;
	logic signed [41:0] k1;
	logic signed [41:0] k2;
	logic signed [41:0] k3;
	logic [15:0] decSat;
	logic [15:0] intSat;
	logic [15:0] sdIn;
	logic [16:0] sdSum;

	// clamp a wide signed value into a 16-bit word
	function automatic logic [15:0] sat16(input logic signed [41:0] v);
		if (v > 42'sh0_0000_7fff) begin
			return 16'h7fff;
		end else if (v < -42'sh0_0000_8000) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction

	// input gain table in dB
	function automatic logic [5:0] inDb(input logic [2:0] code);
		unique case (code)
			3'h0: return 6'h00;
			3'h1: return 6'h06;
			3'h2: return 6'h0c;
			3'h3: return 6'h12;
			3'h4: return 6'h14;
			3'h5: return 6'h1a;
			3'h6: return 6'h20;
			3'h7: return 6'h26;
		endcase
	endfunction

	// mode decode and timing strobes
	assign dataMode = r.portMode[`CS3_PM_DATA];
	assign mixedMode = dataMode && r.portMode[`CS3_PM_MIXED];
	assign bypass = r.filtCtl[`CS3_FC_BYPASS];
	assign mclkTick = (r.divCnt == 8'(MCLK_DIV - 1));
	assign modTick = mclkTick && (r.ph8 == `CS3_MOD_DIV);
	assign nMax = 9'((`CS3_BASE_RATIO << r.rate) - 9'h001);
	assign sampTick = modTick && (r.sCnt == nMax);

	// decimator comb section, evaluated once per sample
	assign xin = r.syn[1] ? 26'sh1 : -26'sh1;
	assign c1 = r.i3 - r.d1;
	assign c2 = c1 - r.d2;
	assign c3 = c2 - r.d3;
	// rescale 3*log2(N) growth down to 16 bits
	assign decSat = sat16(42'(c3 >>> (3 * r.rate)));

	// interpolator comb on the held DAC word
	assign u = 42'(signed'(r.dacHold));
	assign k1 = u - r.e1;
	assign k2 = k1 - r.e2;
	assign k3 = k2 - r.e3;
	// zero-stuffed integrators have gain N^2
	assign intSat = sat16(r.j3 >>> (10 + 2 * r.rate));
	assign sdIn = bypass ? r.dacHold : intSat;
	assign sdSum = {1'b0, r.sdAcc} + {1'b0, sdIn ^ 16'h8000};

	// DAC word intake from the serial port side
	assign accept = dacValid && dataMode && (!mixedMode || dacWord[15] == `CS3_DATA_FLAG);

	// APB decode
	assign apbWr = psel && penable && pwrite;
	assign hit = (paddr == `CS3_OFS_PORT) || (paddr == `CS3_OFS_GAIN) ||
		(paddr == `CS3_OFS_FILT) || (paddr == `CS3_OFS_RATE) ||
		(paddr == `CS3_OFS_ADC) || (paddr == `CS3_OFS_STAT);

	// next state
	always_comb begin
		n = r;
		n.syn = {r.syn[0], adcModBit};
		n.divCnt = mclkTick ? 8'h00 : r.divCnt + 8'h01;
		if (mclkTick) begin
			n.ph8 = r.ph8 + 3'h1;
		end
		if (modTick) begin
			n.sCnt = sampTick ? 9'h000 : r.sCnt + 9'h001;
			n.i1 = r.i1 + xin;
			n.i2 = r.i2 + r.i1;
			n.i3 = r.i3 + r.i2;
			n.j1 = r.j1 + (sampTick ? k3 : 42'sh0);
			n.j2 = r.j2 + r.j1;
			n.j3 = r.j3 + r.j2;
			n.sdAcc = sdSum[15:0];
			n.dacBit = sdSum[16];
		end
		n.adcValid = sampTick;
		if (sampTick) begin
			n.d1 = r.i3;
			n.d2 = c1;
			n.d3 = c2;
			n.e1 = u;
			n.e2 = k1;
			n.e3 = k2;
			n.dacHold = r.dacPend;
			n.dacFresh = 1'b0;
			if (mixedMode) begin
				n.adcWord = {`CS3_DATA_FLAG, decSat[15:1]};
			end else if (r.rate == 2'h0) begin
				n.adcWord = {decSat[15:2], 2'b00};
			end else begin
				n.adcWord = decSat;
			end
		end
		// a word arriving with the period boundary still counts as fresh
		if (accept) begin
			n.dacPend = mixedMode ? {dacWord[14:0], 1'b0} : dacWord;
			n.dacFresh = 1'b1;
		end
		// register writes take effect in the access phase
		if (apbWr) begin
			unique case (paddr)
				`CS3_OFS_PORT: n.portMode = pwdata[7:0];
				`CS3_OFS_GAIN: n.gainCtl = pwdata[7:0];
				`CS3_OFS_FILT: n.filtCtl = pwdata[7:0];
				// restart the period count so a smaller ratio cannot strand it above N-1
				`CS3_OFS_RATE: begin
					n.rate = pwdata[1:0];
					n.sCnt = 9'h000;
				end
				default: n.rate = r.rate;
			endcase
		end
		// read data is captured in the setup phase
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`CS3_OFS_PORT: n.prdata = {24'h0, r.portMode};
				`CS3_OFS_GAIN: n.prdata = {24'h0, r.gainCtl};
				`CS3_OFS_FILT: n.prdata = {24'h0, r.filtCtl};
				`CS3_OFS_RATE: n.prdata = {30'h0, r.rate};
				`CS3_OFS_ADC: n.prdata = {16'h0, r.adcWord};
				`CS3_OFS_STAT: n.prdata = {31'h0, r.dacFresh};
				default: n.prdata = 32'h0;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// outputs
	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign modStrobe = modTick;
	assign adcWord = r.adcWord;
	assign adcValid = r.adcValid;
	assign dacBit = r.dacBit;
	assign inGainDb = inDb(r.gainCtl[`CS3_GC_IN_LSB +: 3]);
	assign outGainDb = 5'sh06 - 5'(3 * r.gainCtl[`CS3_GC_OUT_LSB +: 3]);

	// checks
	AST_MOD_RATE: assert property (@(posedge sys_clk) disable iff (rst)
		modTick |=> !modTick [*7]) else $error("modulator strobe faster than 1/8");
	AST_SAMP_ON_MOD: assert property (@(posedge sys_clk) disable iff (rst)
		sampTick |-> modTick && r.sCnt == nMax) else $error("sample tick off grid");
	AST_RATIO: assert property (@(posedge sys_clk) disable iff (rst)
		r.rate == 2'h0 |-> nMax == 9'h01f) else $error("ratio not 32 at top rate");
	AST_LSB_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
		adcValid && r.rate == 2'h0 && !mixedMode |-> adcWord[1:0] == 2'b00)
		else $error("adc lsbs not zero");
	AST_MIXED_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
		adcValid && mixedMode |-> adcWord[15] == `CS3_DATA_FLAG)
		else $error("mixed flag wrong");
	AST_VALID_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
		sampTick |=> adcValid ##1 !adcValid) else $error("adc valid not a pulse");
	AST_REUSE: assert property (@(posedge sys_clk) disable iff (rst)
		sampTick |=> r.dacHold == $past(r.dacPend)) else $error("hold not refreshed");
	AST_BYPASS: assert property (@(posedge sys_clk) disable iff (rst)
		bypass |-> sdIn == r.dacHold) else $error("bypass not taken");
	AST_IN_GAIN: assert property (@(posedge sys_clk) disable iff (rst)
		r.gainCtl[2:0] == 3'h4 |-> inGainDb == 6'h14) else $error("input gain table");
	AST_OUT_GAIN: assert property (@(posedge sys_clk) disable iff (rst)
		r.gainCtl[6:4] == 3'h7 |-> outGainDb == -5'sh0f) else $error("output gain table");
	AST_FRESH: assert property (@(posedge sys_clk) disable iff (rst)
		accept |=> r.dacFresh) else $error("fresh flag lost");
endmodule // cs3_datapath
`default_nettype wire

// ==== src/cs3_params.svh ====
// constants for the sinc3 codec datapath
`ifndef CS3_PARAMS_SVH
`define CS3_PARAMS_SVH
`define CS3_OFS_PORT 8'h00
`define CS3_OFS_GAIN 8'h04
`define CS3_OFS_FILT 8'h08
`define CS3_OFS_RATE 8'h0c
`define CS3_OFS_ADC 8'h10
`define CS3_OFS_STAT 8'h14
`define CS3_PM_DATA 0
`define CS3_PM_MIXED 1
`define CS3_FC_BYPASS 5
`define CS3_GC_IN_LSB 0
`define CS3_GC_OUT_LSB 4
`define CS3_RST_REG 8'h00
`define CS3_MOD_DIV 3'h7
`define CS3_BASE_RATIO 9'h020
`define CS3_DATA_FLAG 1'b0
`endif

// ==== src/cs3_pkg.sv ====
// types for the sinc3 codec datapath
`default_nettype none
package cs3_pkg;
	typedef struct packed {
		logic [7:0] divCnt;
		logic [2:0] ph8;
		logic [8:0] sCnt;
		logic [7:0] portMode;
		logic [7:0] gainCtl;
		logic [7:0] filtCtl;
		logic [1:0] rate;
		logic [1:0] syn;
		logic signed [25:0] i1;
		logic signed [25:0] i2;
		logic signed [25:0] i3;
		logic signed [25:0] d1;
		logic signed [25:0] d2;
		logic signed [25:0] d3;
		logic [15:0] adcWord;
		logic adcValid;
		logic [15:0] dacPend;
		logic dacFresh;
		logic [15:0] dacHold;
		logic signed [41:0] e1;
		logic signed [41:0] e2;
		logic signed [41:0] e3;
		logic signed [41:0] j1;
		logic signed [41:0] j2;
		logic signed [41:0] j3;
		logic [15:0] sdAcc;
		logic dacBit;
		logic [31:0] prdata;
	} cs3_state_t;
endpackage
`default_nettype wire

// ==== testbench/cs3_host_model.sv ====
// host side model: sends one dac word per request
`default_nettype none
module cs3_host_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sendReq,
	input wire logic [15:0] sendWord,
	output logic dacValid,
	output logic [15:0] dacWord
);
	timeunit 1ns;
	timeprecision 1ns;
	// one-cycle strobe; idle word toggles so stale data never looks valid
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dacValid <= 1'h0;
			dacWord <= 16'h0000;
		end else if (sendReq) begin
			dacValid <= 1'h1;
			dacWord <= sendWord;
		end else begin
			dacValid <= 1'h0;
			dacWord <= ~dacWord;
		end
	end
endmodule // cs3_host_model
`default_nettype wire

// ==== testbench/cs3_datapath_tb.sv ====
// self-checking bench for the sinc3 codec datapath
`default_nettype none
module cs3_datapath_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic adcModBit = 1'h1;
	logic sendReq = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, e, modStrobe, adcValid, dacValid, dacBit;
	logic [15:0] adcWord, dacWord;
	logic [15:0] sendWord = 16'h0000;
	logic [5:0] inGainDb;
	logic signed [4:0] outGainDb;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	logic [5:0] ig[8] = '{0, 6, 12, 18, 20, 26, 32, 38};
	logic signed [4:0] og[8] = '{6, 3, 0, -3, -6, -9, -12, -15};

	cs3_datapath #(.MCLK_DIV(1)) dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .adcModBit, .modStrobe, .adcWord, .adcValid,
		.dacValid, .dacWord, .dacBit, .inGainDb, .outGainDb);
	cs3_host_model host (.sys_clk, .rst, .sendReq, .sendWord, .dacValid, .dacWord);

	// clock and hang guard
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one apb transfer; result left in q and e, settled at the negedge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1) @(posedge sys_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(negedge sys_clk);
	endtask

	// cycles up to the next adc sample strobe
	task automatic wait_adc();
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (adcValid !== 1'h1 && n < 5000);
	endtask

	task automatic send(input logic [15:0] w);
		@(posedge sys_clk);
		sendReq <= 1'h1;
		sendWord <= w;
		@(posedge sys_clk);
		sendReq <= 1'h0;
	endtask

	// send a dac word just after a sample tick, then read the fresh flag
	task automatic dac_case(input logic [31:0] mode, input logic [15:0] w, input logic exp);
		apb(1'h1, 8'h00, mode);
		wait_adc();
		send(w);
		apb(1'h0, 8'h14, 32'h0);
		chk(q[0], exp);
	endtask

	// bypassed dac word, then modulator ones over 64 strobes
	task automatic count_bits(input logic [15:0] w);
		apb(1'h1, 8'h00, 32'h1);
		send(w);
		repeat (2) wait_adc();
		n = 0;
		repeat (512) begin
			@(negedge sys_clk);
			if (modStrobe) n += dacBit;
		end
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		for (int a = 0; a < 7; a++) begin
			apb(1'h0, 8'(a * 4), 32'h0);
			if (a < 6) chk(q, 32'h0);
			chk(e, a == 6);
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'h1, 8'h04, 32'(i * 17));
			chk(inGainDb, ig[i]);
			chk(outGainDb, og[i]);
		end
		n = 0;
		repeat (64) begin
			@(negedge sys_clk);
			n += modStrobe;
		end
		chk(n, 8);
		apb(1'h1, 8'h00, 32'h1);
		repeat (4) wait_adc();
		chk(n, 256);
		chk(adcWord[15], 1'h0);
		chk(adcWord[1:0], 2'h0);
		chk(adcWord, 16'h7ffc);
		@(posedge sys_clk);
		adcModBit <= 1'h0;
		repeat (4) wait_adc();
		chk(adcWord[15], 1'h1);
		chk(adcWord, 16'h8000);
		apb(1'h1, 8'h00, 32'h3);
		repeat (2) wait_adc();
		chk(adcWord[15], 1'h0);
		chk(adcWord, 16'h4000);
		apb(1'h1, 8'h0c, 32'h3);
		repeat (3) wait_adc();
		chk(n, 2048);
		apb(1'h1, 8'h0c, 32'h0);
		dac_case(32'h1, 16'h7fff, 1'h1);
		wait_adc();
		apb(1'h0, 8'h14, 32'h0);
		chk(q[0], 1'h0);
		dac_case(32'h0, 16'h8000, 1'h0);
		dac_case(32'h3, 16'h8000, 1'h0);
		dac_case(32'h3, 16'h0123, 1'h1);
		apb(1'h1, 8'h08, 32'h20);
		apb(1'h0, 8'h08, 32'h0);
		chk(q, 32'h20);
		count_bits(16'h8000);
		chk(n, 0);
		count_bits(16'h7fff);
		chk(n >= 63, 1'h1);
		finish_test();
	end
endmodule // cs3_datapath_tb
`default_nettype wire
